/* File: design/jcg_crc_gen.sv */
`timescale 1ns/1ps
// Functional notes
// - crc9 uses x^9+x^3+x^2+1 over count-delta bits of octets one, two, four, five
// - crc9 message: octet four bits 2-8, octet one, octet five, octet two
// - crc9 bit 1 into octet six bit 2, bit 9 into octet three bit 2
// - each crc9 bit is a fixed xor of eighteen message bits
// - crc8 uses x^8+x^3+x^2+1 over octets one and two
// - crc8 message: octet one msb first, octet two bits, increment, decrement
// - crc8 fills octet three, bit 1 at msb
// - each crc8 bit is a fixed xor of sixteen message bits
// - crc5 uses x^5+x+1 over five bits each of octets four and five
// - crc5 bits go to octet six bits 4 to 8
// - each crc5 bit is a fixed xor of ten message bits
// - crc6 uses x^6+x^3+x^2+1 over octets one and two
// - crc6 message starts at octet one bit 3, ends with the indicators
// - crc6 occupies octet three bit 3 down to lsb
// - each crc6 bit is a fixed xor of twelve message bits
module jcg_crc_gen
  import jcg_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire jcg_variant_t variant_sel,
  input  wire logic         tx_valid,
  input  wire logic [7:0]   tx_oct1,
  input  wire logic [7:0]   tx_oct2,
  input  wire logic [7:0]   tx_oct3,
  input  wire logic [7:0]   tx_oct4,
  input  wire logic [7:0]   tx_oct5,
  input  wire logic [7:0]   tx_oct6,
  output logic              tx_out_valid,
  output logic      [7:0]   tx_oct3_out,
  output logic      [7:0]   tx_oct6_out,
  input  wire logic         rx_valid,
  input  wire logic [7:0]   rx_oct1,
  input  wire logic [7:0]   rx_oct2,
  input  wire logic [7:0]   rx_oct3,
  input  wire logic [7:0]   rx_oct4,
  input  wire logic [7:0]   rx_oct5,
  input  wire logic [7:0]   rx_oct6,
  output logic              rx_chk_valid,
  output logic              rx_crc_err
);
  logic [8:0] t9, r9;
  logic [7:0] t8, r8;
  logic [4:0] t5, r5;
  logic [5:0] t6, r6;
  logic [7:0] nxt_oct3, nxt_oct6;
  logic       nxt_err;
  logic       tx_valid_ff, rx_valid_ff, err_ff;
  logic [7:0] oct3_ff, oct6_ff;

  jcg_crc_core u_tx_core (
    .oct1 (tx_oct1),
    .oct2 (tx_oct2),
    .oct4 (tx_oct4),
    .oct5 (tx_oct5),
    .crc9 (t9),
    .crc8 (t8),
    .crc5 (t5),
    .crc6 (t6)
  );

  jcg_crc_core u_rx_core (
    .oct1 (rx_oct1),
    .oct2 (rx_oct2),
    .oct4 (rx_oct4),
    .oct5 (rx_oct5),
    .crc9 (r9),
    .crc8 (r8),
    .crc5 (r5),
    .crc6 (r6)
  );

  // octet bit n (msb = 1) is vector index 8-n
  // insert only the selected field
  always_comb begin
    nxt_oct3 = tx_oct3;
    nxt_oct6 = tx_oct6;
    unique case (variant_sel)
      JCG_CRC9: begin
        nxt_oct6[6:0] = t9[8:2];
        nxt_oct3[6]   = t9[0];
      end
      JCG_CRC8: begin
        nxt_oct3 = t8;
      end
      JCG_CRC5: begin
        nxt_oct6[4:0] = t5;
      end
      JCG_CRC6: begin
        nxt_oct3[5:0] = t6;
      end
    endcase
  end

  always_comb begin
    unique case (variant_sel)
      JCG_CRC9: nxt_err = ({rx_oct6[6:0], rx_oct3[6]} != {r9[8:2], r9[0]});
      JCG_CRC8: nxt_err = (rx_oct3 != r8);
      JCG_CRC5: nxt_err = (rx_oct6[4:0] != r5);
      JCG_CRC6: nxt_err = (rx_oct3[5:0] != r6);
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_valid_ff <= 1'b0;
      oct3_ff     <= JCG_OCTET_RST;
      oct6_ff     <= JCG_OCTET_RST;
    end else begin
      tx_valid_ff <= tx_valid;
      if (tx_valid) begin
        oct3_ff <= nxt_oct3;
        oct6_ff <= nxt_oct6;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_valid_ff <= 1'b0;
      err_ff      <= 1'b0;
    end else begin
      rx_valid_ff <= rx_valid;
      if (rx_valid) begin
        err_ff <= nxt_err;
      end
    end
  end

  assign tx_out_valid = tx_valid_ff;
  assign tx_oct3_out  = oct3_ff;
  assign tx_oct6_out  = oct6_ff;
  assign rx_chk_valid = rx_valid_ff;
  assign rx_crc_err   = err_ff;

  property p_tx_lat;
    @(posedge core_clk) disable iff (rst) tx_valid |=> tx_out_valid;
  endproperty
  a_tx_lat: assert property (p_tx_lat) else $error("tx output not valid one cycle later");

  property p_crc8_ins;
    @(posedge core_clk) disable iff (rst)
      (tx_valid && variant_sel == JCG_CRC8) |=> tx_oct3_out == $past(t8);
  endproperty
  a_crc8_ins: assert property (p_crc8_ins) else $error("crc8 not in octet three");

  property p_crc5_ins;
    @(posedge core_clk) disable iff (rst)
      (tx_valid && variant_sel == JCG_CRC5) |=> tx_oct6_out[4:0] == $past(t5)
        && tx_oct6_out[7:5] == $past(tx_oct6[7:5]) && tx_oct3_out == $past(tx_oct3);
  endproperty
  a_crc5_ins: assert property (p_crc5_ins) else $error("crc5 placement wrong");

  property p_crc6_ins;
    @(posedge core_clk) disable iff (rst)
      (tx_valid && variant_sel == JCG_CRC6) |=> tx_oct3_out[5:0] == $past(t6)
        && tx_oct3_out[7:6] == $past(tx_oct3[7:6]);
  endproperty
  a_crc6_ins: assert property (p_crc6_ins) else $error("crc6 placement wrong");

  property p_crc9_ins;
    @(posedge core_clk) disable iff (rst)
      (tx_valid && variant_sel == JCG_CRC9) |=> tx_oct6_out[6] == $past(t9[8])
        && tx_oct3_out[6] == $past(t9[0]) && tx_oct6_out[7] == $past(tx_oct6[7]);
  endproperty
  a_crc9_ins: assert property (p_crc9_ins) else $error("crc9 placement wrong");

  property p_c8_bit1;
    @(posedge core_clk) disable iff (rst)
      1'b1 |-> t8[7] == (tx_oct1[6] ^ tx_oct1[3] ^ tx_oct1[1] ^ tx_oct2[7] ^ tx_oct2[5]
                         ^ tx_oct2[4]);
  endproperty
  a_c8_bit1: assert property (p_c8_bit1) else $error("crc8 bit 1 equation");

  property p_c5_bit1;
    @(posedge core_clk) disable iff (rst)
      1'b1 |-> t5[4] == (tx_oct4[4] ^ tx_oct4[2] ^ tx_oct5[4] ^ tx_oct5[3]);
  endproperty
  a_c5_bit1: assert property (p_c5_bit1) else $error("crc5 bit 1 equation");

  property p_c6_bit1;
    @(posedge core_clk) disable iff (rst)
      1'b1 |-> t6[5] == (tx_oct1[4] ^ tx_oct1[3] ^ tx_oct1[2] ^ tx_oct1[1] ^ tx_oct2[3]
                         ^ tx_oct2[2]);
  endproperty
  a_c6_bit1: assert property (p_c6_bit1) else $error("crc6 bit 1 equation");

  property p_c9_bit1;
    @(posedge core_clk) disable iff (rst)
      1'b1 |-> t9[8] == (tx_oct4[2] ^ tx_oct4[0] ^ tx_oct5[6] ^ tx_oct5[4] ^ tx_oct5[3]);
  endproperty
  a_c9_bit1: assert property (p_c9_bit1) else $error("crc9 bit 1 equation");

  property p_rx_err;
    @(posedge core_clk) disable iff (rst)
      (rx_valid && variant_sel == JCG_CRC8 && rx_oct3 != r8) |=> rx_crc_err && rx_chk_valid;
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("crc8 mismatch not flagged");

  property p_rx_lat;
    @(posedge core_clk) disable iff (rst) rx_valid |=> rx_chk_valid;
  endproperty
  a_rx_lat: assert property (p_rx_lat) else $error("rx check not valid one cycle later");

  property p_rx_hold;
    @(posedge core_clk) disable iff (rst) !rx_valid |=> $stable(rx_crc_err) && !rx_chk_valid;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx flag moved while idle");

  c_tx9: cover property (@(posedge core_clk) disable iff (rst)
    tx_valid && variant_sel == JCG_CRC9);
  c_tx5: cover property (@(posedge core_clk) disable iff (rst)
    tx_valid && variant_sel == JCG_CRC5);
  c_rx_err: cover property (@(posedge core_clk) disable iff (rst) rx_chk_valid && rx_crc_err);
  c_rx_ok: cover property (@(posedge core_clk) disable iff (rst) rx_chk_valid && !rx_crc_err);
endmodule

/* File: design/jcg_pkg.sv */
package jcg_pkg;

  // check variant select codes
  typedef enum logic [1:0] {
    JCG_CRC9 = 2'b00,
    JCG_CRC8 = 2'b01,
    JCG_CRC5 = 2'b10,
    JCG_CRC6 = 2'b11
  } jcg_variant_t;

  localparam int unsigned JCG_OCTET_W   = 8;
  localparam int unsigned JCG_CRC9_W    = 9;
  localparam int unsigned JCG_CRC8_W    = 8;
  localparam int unsigned JCG_CRC5_W    = 5;
  localparam int unsigned JCG_CRC6_W    = 6;
  localparam int unsigned JCG_MSG9_W    = 18;
  localparam int unsigned JCG_MSG8_W    = 16;
  localparam int unsigned JCG_MSG5_W    = 10;
  localparam int unsigned JCG_MSG6_W    = 12;
  // increment/decrement indicator positions in octet two (bit 7 / bit 8, msb = bit 1)
  localparam int unsigned JCG_INC_POS   = 1;
  localparam int unsigned JCG_DEC_POS   = 0;
  localparam logic [7:0]  JCG_OCTET_RST = 8'h00;

  // xor masks: bit (w-k) of mask j selects message bit k for check bit j+1
  localparam logic [17:0] JCG_C9_MASK [9] = '{
    18'h02960, 18'h214b0, 18'h30a58, 18'h1852c, 18'h0c296,
    18'h2614b, 18'h119c5, 18'h0a582, 18'h052c1};
  localparam logic [15:0] JCG_C8_MASK [8] = '{
    16'h4ab0, 16'ha558, 16'h52ac, 16'h2956,
    16'h14ab, 16'hc0e5, 16'h2ac2, 16'h9561};
  localparam logic [9:0]  JCG_C5_MASK [5] = '{
    10'h298, 10'h14c, 10'h2a6, 10'h353, 10'h131};
  localparam logic [11:0] JCG_C6_MASK [6] = '{
    12'h78c, 12'h3c6, 12'h9e3, 12'h37d, 12'he32, 12'hf19};

endpackage

/* File: design/jcg_crc_core.sv */
`timescale 1ns/1ps
module jcg_crc_core
  import jcg_pkg::*;
(
  input  wire logic [7:0] oct1,
  input  wire logic [7:0] oct2,
  input  wire logic [7:0] oct4,
  input  wire logic [7:0] oct5,
  output logic      [8:0] crc9,
  output logic      [7:0] crc8,
  output logic      [4:0] crc5,
  output logic      [5:0] crc6
);
  logic [17:0] msg9;
  logic [15:0] msg8;
  logic [9:0]  msg5;
  logic [11:0] msg6;

  // msb of each vector is message bit 1
  // crc9 message order
  assign msg9 = {oct4[6:0], oct1[1:0], oct5[6:0], oct2[1:0]};
  assign msg8 = {oct1, oct2[7:2], oct2[JCG_INC_POS], oct2[JCG_DEC_POS]};
  assign msg5 = {oct4[4:0], oct5[4:0]};
  assign msg6 = {oct1[5:0], oct2[5:2], oct2[JCG_INC_POS], oct2[JCG_DEC_POS]};

  always_comb begin
    for (int j = 0; j < JCG_CRC9_W; j++) begin
      crc9[JCG_CRC9_W-1-j] = ^(msg9 & JCG_C9_MASK[j]);
    end
    for (int j = 0; j < JCG_CRC8_W; j++) begin
      crc8[JCG_CRC8_W-1-j] = ^(msg8 & JCG_C8_MASK[j]);
    end
    for (int j = 0; j < JCG_CRC5_W; j++) begin
      crc5[JCG_CRC5_W-1-j] = ^(msg5 & JCG_C5_MASK[j]);
    end
    for (int j = 0; j < JCG_CRC6_W; j++) begin
      crc6[JCG_CRC6_W-1-j] = ^(msg6 & JCG_C6_MASK[j]);
    end
  end
endmodule

/* File: verif/jcg_peer_model.sv */
`timescale 1ns/1ps
module jcg_peer_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        tx_valid,
  input  wire logic [47:0] tx_frame,
  input  wire logic [15:0] flip,
  input  wire logic        tx_out_valid,
  input  wire logic [15:0] ins_octs,
  output logic             rx_valid,
  output logic      [47:0] rx_frame
);
  logic [47:0] frm_ff;
  logic [15:0] flip_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frm_ff  <= '0;
      flip_ff <= '0;
    end else if (tx_valid) begin
      frm_ff  <= tx_frame;
      flip_ff <= flip;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_frame <= '0;
    end else begin
      rx_valid <= tx_out_valid;
      if (tx_out_valid)
        rx_frame <= {frm_ff[47:32], ins_octs[15:8] ^ flip_ff[15:8], frm_ff[23:8],
                     ins_octs[7:0] ^ flip_ff[7:0]};
      else
        rx_frame <= ~rx_frame;
    end
  end
endmodule

/* File: verif/justification_crc_gen_test.sv */
`timescale 1ns/1ps
module justification_crc_gen_test;
  import jcg_pkg::*;
  logic         core_clk = 1'b0;
  logic         rst = 1'b1;
  jcg_variant_t variant_sel = JCG_CRC9;
  logic         tx_valid = 1'b0;
  logic [47:0]  tx_frame = '0;
  logic [15:0]  flip = '0;
  logic         tx_out_valid, rx_valid, rx_chk_valid, rx_crc_err;
  logic [7:0]   tx_oct3_out, tx_oct6_out;
  logic [47:0]  rx_frame;
  logic [31:0]  seed = 32'hf9e1;
  logic [15:0]  tx_q[$];
  logic [15:0]  rx_q[$];
  int           n_errors = 0;
  int           n_tests = 0;
  int           cycles = 0;
  always #12.5 core_clk = ~core_clk;
  jcg_crc_gen u_dut (.core_clk(core_clk), .rst(rst), .variant_sel(variant_sel),
    .tx_valid(tx_valid), .tx_oct1(tx_frame[47:40]), .tx_oct2(tx_frame[39:32]),
    .tx_oct3(tx_frame[31:24]), .tx_oct4(tx_frame[23:16]), .tx_oct5(tx_frame[15:8]),
    .tx_oct6(tx_frame[7:0]), .tx_out_valid(tx_out_valid), .tx_oct3_out(tx_oct3_out),
    .tx_oct6_out(tx_oct6_out), .rx_valid(rx_valid), .rx_oct1(rx_frame[47:40]),
    .rx_oct2(rx_frame[39:32]), .rx_oct3(rx_frame[31:24]), .rx_oct4(rx_frame[23:16]),
    .rx_oct5(rx_frame[15:8]), .rx_oct6(rx_frame[7:0]), .rx_chk_valid(rx_chk_valid),
    .rx_crc_err(rx_crc_err));
  jcg_peer_model u_peer (.core_clk(core_clk), .rst(rst), .tx_valid(tx_valid),
    .tx_frame(tx_frame), .flip(flip), .tx_out_valid(tx_out_valid),
    .ins_octs({tx_oct3_out, tx_oct6_out}), .rx_valid(rx_valid), .rx_frame(rx_frame));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // serial division, first message bit at msb, check bit 1 at msb
  function automatic logic [8:0] crc(input logic [17:0] m, input int n, input int w,
                                     input logic [8:0] p);
    logic [8:0] r;
    r = '0;
    for (int i = n - 1; i >= 0; i--) r = (r << 1) ^ ((m[i] ^ r[w-1]) ? p : 9'h000);
    return r & ((9'h001 << w) - 9'h001);
  endfunction
  // octets three and six as they should leave the mapper
  function automatic logic [15:0] ins(input jcg_variant_t v, input logic [47:0] f);
    logic [7:0] o1, o2, o3, o4, o5, o6;
    logic [8:0] c9, c8, c5, c6;
    {o1, o2, o3, o4, o5, o6} = f;
    c9 = crc({o4[6:0], o1[1:0], o5[6:0], o2[1:0]}, 18, 9, 9'h00d);
    c8 = crc({o1, o2}, 16, 8, 9'h00d);
    c5 = crc({o4[4:0], o5[4:0]}, 10, 5, 9'h003);
    c6 = crc({o1[5:0], o2[5:0]}, 12, 6, 9'h00d);
    case (v)
      JCG_CRC9: return {o3[7], c9[0], o3[5:0], o6[7], c9[8:2]};
      JCG_CRC8: return {c8[7:0], o6};
      JCG_CRC5: return {o3, o6[7:5], c5[4:0]};
      default:  return {o3[7:6], c6[5:0], o6};
    endcase
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic finish_test;
    $display("counts: tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic send(input logic [47:0] f, input logic [15:0] fl, input int gap);
    logic [15:0] e;
    logic [47:0] r;
    e = ins(variant_sel, f);
    r = {f[47:32], e[15:8] ^ fl[15:8], f[23:8], e[7:0] ^ fl[7:0]};
    tx_q.push_back(e);
    rx_q.push_back({15'h0, ins(variant_sel, r) !== {r[31:24], r[7:0]}});
    tx_valid <= 1'b1;
    tx_frame <= f;
    flip <= fl;
    @(posedge core_clk);
    if (gap > 0) begin
      tx_valid <= 1'b0;
      repeat (gap) @(posedge core_clk);
    end
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      finish_test();
    end
    if (!rst && tx_out_valid === 1'b1)
      check({tx_oct3_out, tx_oct6_out}, tx_q.pop_front());
    if (!rst && rx_chk_valid === 1'b1)
      check({15'h0, rx_crc_err}, rx_q.pop_front());
  end
  initial begin
    logic [47:0] f;
    repeat (3) @(posedge core_clk);
    check({tx_oct3_out, tx_oct6_out}, 16'h0000);
    check({13'h0, tx_out_valid, rx_chk_valid, rx_crc_err}, 16'h0000);
    rst <= 1'b0;
    for (int v = 0; v < 4; v++) begin
      variant_sel <= jcg_variant_t'(v);
      repeat (3) @(posedge core_clk);
      send('0, '0, 1);
      send('1, '0, 0);
      for (int b = 0; b < 48; b += 5) send(48'h1 << b, '0, 0);
      // every single-bit corruption of octets three and six
      for (int b = 0; b < 16; b++) send(48'h5a3c_96e1_0ff0, 16'h0001 << b, b % 2);
      for (int k = 0; k < 60; k++) begin
        seed = xorshift(seed);
        f = {seed, seed[31:16] ^ seed[15:0]};
        send(f, (seed[1:0] == 2'b00) ? 16'h0001 << seed[7:4] : 16'h0000, int'(seed[9:8]));
      end
      send(f, '0, 4);
      $display("test variant %0d done", v);
    end
    check(16'(tx_q.size() + rx_q.size()), 16'h0000);
    finish_test();
  end
endmodule
